// file: hdl/np_regs_defines.svh
// Purpose: offsets, bit positions and reset values of the next-page register bank
// Assumes: 5-bit management register address, 16-bit data
// Notes:   included by the autoneg_next_page_regs module only
`ifndef NP_REGS_DEFINES_SVH
`define NP_REGS_DEFINES_SVH
`define ADDR_EXPANSION      5'h06
`define ADDR_NP_TRANSMIT    5'h07
`define ADDR_NP_PARTNER     5'h08
`define EXP_PAGE_RX_BIT     1
`define EXP_LOCAL_NP_BIT    2
`define EXP_PARTNER_NP_BIT  3
`define EXP_PAR_FAULT_BIT   4
`define EXP_PARTNER_AN_BIT  0
`define NP_TX_RESET         16'h2001
`define NP_RX_RESET         16'h0000
`define CODE_W              11
`define LOCAL_NP_ABLE       1'b1
`endif

// file: hdl/np_regs_pkg.sv
// Purpose: types shared by the next-page register bank
// Assumes: page word layout of the auto-negotiation next page
// Notes:   field order matches bit 15 down to bit 0
package np_regs_pkg;
  typedef struct packed {
    logic        next_page;
    logic        reserved;
    logic        message_page;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } np_word_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;
endpackage

// file: hdl/np_word_store.sv
// Purpose: one 16-bit page word held in a register, loaded on demand
// Assumes: single clock, asynchronous active-low reset
// Notes:   reset value is a parameter so both page words can use it
`timescale 1ns/1ps
module np_word_store #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic        ref_clk, // clock
  input  wire logic        arst_n,  // asynchronous reset, low
  input  wire logic        load,    // take new word
  input  wire logic [15:0] din,     // new word
  output logic      [15:0] dout     // stored word
);
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      dout <= RESET_VAL;
    else if (load)
      dout <= din;
  end
endmodule

// file: hdl/autoneg_next_page_regs.sv
// Purpose: expansion, next-page transmit and partner next-page registers
// Assumes: management logic decodes the serial frame into a request strobe;
//          link-side event strobes come from arbitration logic on ref_clk
// Notes:   read data registered one cycle after rd_en
`timescale 1ns/1ps
`include "np_regs_defines.svh"
module autoneg_next_page_regs #(
  parameter int CODE_W = `CODE_W // width of the message or unformatted code field
) (
  input  wire logic                   ref_clk,        // 100 MHz clock
  input  wire logic                   arst_n,         // asynchronous reset, low
  input  wire np_regs_pkg::mgmt_req_t req,            // management request
  output logic [15:0]                 rdata,          // read data
  output logic                        rvalid,         // read data valid pulse
  input  wire logic                   page_rx_evt,    // partner page arrived
  input  wire np_regs_pkg::np_word_t  page_rx_word,   // partner page word
  input  wire logic                   par_fault_evt,  // several technologies seen
  input  wire logic                   partner_np,     // partner announced next page
  input  wire logic                   partner_an,     // partner is autoneg able
  input  wire logic                   page_tx_done,   // local page sent
  output np_regs_pkg::np_word_t       tx_word         // page to transmit
);
  import np_regs_pkg::*;

  // the page word layout leaves room for an eleven-bit code field only
  if (CODE_W != 11)
  begin : g_code_w_check
    $error("code field width must be eleven");
  end

  logic     page_rx_r;
  logic     par_fault_r;
  logic     toggle_r;
  logic     rd_clr;
  logic     wr_tx;
  logic [15:0] tx_q;
  logic [15:0] tx_din;
  logic [15:0] rx_q;
  logic [15:0] exp_word;
  np_word_t tx_view;

  assign rd_clr = req.rd_en && (req.addr == `ADDR_EXPANSION);
  assign wr_tx  = req.wr_en && (req.addr == `ADDR_NP_TRANSMIT);

  // latched flags clear on read; a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      page_rx_r <= 1'b0;
    else if (page_rx_evt)
      page_rx_r <= 1'b1;
    else if (rd_clr)
      page_rx_r <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      par_fault_r <= 1'b0;
    else if (par_fault_evt)
      par_fault_r <= 1'b1;
    else if (rd_clr)
      par_fault_r <= 1'b0;
  end

  // toggle flips after each sent page, so it shows the inverse of the previous word's value
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      toggle_r <= 1'b0;
    else if (page_tx_done)
      toggle_r <= ~toggle_r;
  end

  // only writable fields are taken; reserved and toggle are masked off
  always_comb
  begin
    tx_din     = req.wdata;
    tx_din[14] = 1'b0;
    tx_din[11] = 1'b0;
  end

  np_word_store #(.RESET_VAL(`NP_TX_RESET)) u_tx (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .load    (wr_tx),
    .din     (tx_din),
    .dout    (tx_q)
  );

  np_word_store #(.RESET_VAL(`NP_RX_RESET)) u_rx (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .load    (page_rx_evt),
    .din     ({page_rx_word[15], 1'b0, page_rx_word[13:0]}),
    .dout    (rx_q)
  );

  always_comb
  begin
    tx_view        = np_word_t'(tx_q);
    tx_view.toggle = toggle_r;
    exp_word       = 16'h0000;
    exp_word[`EXP_PAGE_RX_BIT]    = page_rx_r;
    exp_word[`EXP_LOCAL_NP_BIT]   = `LOCAL_NP_ABLE;
    exp_word[`EXP_PARTNER_NP_BIT] = partner_np;
    exp_word[`EXP_PAR_FAULT_BIT]  = par_fault_r;
    exp_word[`EXP_PARTNER_AN_BIT] = partner_an;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 16'h0000;
    else if (req.rd_en)
    begin
      unique case (req.addr)
        `ADDR_EXPANSION:   rdata <= exp_word;
        `ADDR_NP_TRANSMIT: rdata <= tx_view;
        `ADDR_NP_PARTNER:  rdata <= rx_q;
        default:           rdata <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rvalid <= 1'b0;
    else
      rvalid <= req.rd_en;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      tx_word <= np_word_t'(`NP_TX_RESET);
    else
      tx_word <= tx_view;
  end

  chk_flag_latches: assert property (@(posedge ref_clk) disable iff (!arst_n)
    page_rx_evt |=> page_rx_r) else $error("page received flag not set");
  chk_flag_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    page_rx_r && !rd_clr |=> page_rx_r) else $error("page received flag dropped");

  // a fault that lands while software reads must survive the read
  sequence fault_then_read;
    par_fault_evt ##1 rd_clr;
  endsequence

  sequence fault_with_read;
    par_fault_evt && rd_clr;
  endsequence

  chk_fault_latch: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fault_then_read |=> par_fault_r == $past(par_fault_evt))
    else $error("fault flag lost");
  chk_set_wins: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fault_with_read |=> par_fault_r)
    else $error("fault clear beat a new event");

  chk_page_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rd_clr && !page_rx_evt |=> !page_rx_r)
    else $error("page received flag not cleared");
  chk_fault_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rd_clr && !par_fault_evt |=> !par_fault_r)
    else $error("fault flag not cleared");
  chk_exp_reserved: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd_en && req.addr == `ADDR_EXPANSION |=> rdata[15:5] == 11'h000)
    else $error("expansion reserved bits set");
  chk_local_np: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd_en && req.addr == `ADDR_EXPANSION |=> rdata[`EXP_LOCAL_NP_BIT])
    else $error("local next page bit not one");
  chk_partner_np: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd_en && req.addr == `ADDR_EXPANSION |=>
    rdata[`EXP_PARTNER_NP_BIT] == $past(partner_np)) else $error("partner np mismatch");
  chk_tx_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_tx |=> tx_q[10:0] == $past(req.wdata[10:0]) && tx_q[12] == $past(req.wdata[12]))
    else $error("transmit word not written");
  chk_toggle_flip: assert property (@(posedge ref_clk) disable iff (!arst_n)
    page_tx_done |=> toggle_r != $past(toggle_r)) else $error("toggle did not flip");
  chk_rx_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
    page_rx_evt |=> rx_q[13:0] == $past(page_rx_word[13:0]) && !rx_q[14])
    else $error("partner page not stored");

  // writes and link events are the only ways either page word may move
  chk_ack2_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_tx |=> tx_q[12] == $past(req.wdata[12]))
    else $error("acknowledge two not written");
  chk_tx_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !wr_tx |=> tx_q == $past(tx_q))
    else $error("transmit word changed unasked");
  chk_tx_masked: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !tx_q[14] && !tx_q[11])
    else $error("masked transmit bits set");
  chk_tx_view: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_word == $past(tx_view))
    else $error("transmit page output stale");
  chk_rx_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !page_rx_evt |=> rx_q == $past(rx_q))
    else $error("partner page changed unasked");
  chk_read_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd_en |=> rvalid)
    else $error("read data valid missing");
endmodule

// file: tb/link_partner_model.sv
// Purpose: link partner side, hands received pages to the bank
// Assumes: page strobe launched just after the rising edge
// Notes:   idle link word changes every cycle so stale pages never look valid
`timescale 1ns/1ps
module link_partner_model (
  input  wire logic                  ref_clk, // clock
  input  wire logic                  send,    // present a page
  input  wire np_regs_pkg::np_word_t pg,      // page to present
  output logic                       evt,     // page strobe
  output np_regs_pkg::np_word_t      word     // page on the link
);
  import np_regs_pkg::*;
  initial evt = 1'b0;
  initial word = '0;
  always @(posedge ref_clk)
  begin
    evt <= send;
    word <= send ? pg : ~word;
  end
endmodule

// file: tb/test_autoneg_next_page_regs.sv
// Purpose: self-checking bench of the next-page register bank
// Assumes: inputs change on the falling edge
// Notes:   read results are matched against a queue of expected words
`timescale 1ns/1ps
module test_autoneg_next_page_regs;
  import np_regs_pkg::*;
  logic        ref_clk = 0, arst_n = 0, par_f = 0, p_np = 0, p_an = 0, tx_done = 0, send = 0;
  mgmt_req_t   req = '0;
  np_word_t    pg = '0, tx_word, rx_word;
  logic [15:0] rdata, w, exp_q[$];
  logic        rvalid, evt;
  logic [31:0] s = 66023;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  autoneg_next_page_regs i_dut (.ref_clk, .arst_n, .req, .rdata, .rvalid,
    .page_rx_evt(evt), .page_rx_word(rx_word), .par_fault_evt(par_f),
    .partner_np(p_np), .partner_an(p_an), .page_tx_done(tx_done), .tx_word);
  link_partner_model i_lp (.ref_clk, .send, .pg, .evt, .word(rx_word));
  function automatic logic [15:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[15:0];
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("ERROR %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic op(logic wr, logic [4:0] a, logic [15:0] d, logic [15:0] e);
    @(negedge ref_clk);
    req = '{wr, !wr, a, d};
    if (!wr) exp_q.push_back(e);
    @(negedge ref_clk);
    req = '0;
  endtask
  task automatic pulse(ref logic x);
    @(negedge ref_clk);
    x = 1'b1;
    @(negedge ref_clk);
    x = 1'b0;
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge ref_clk)
    if (rvalid === 1'b1)
      chk("rdata", exp_q.size() ? exp_q.pop_front() : 16'hDEAD, rdata);
  // bound on the whole run, far above the fewer than fifty cycles used
  always @(posedge ref_clk)
    if (++cyc > 3000)
    begin
      error_cnt++;
      close_out();
    end
  initial
  begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("tx_word", 16'h2001, tx_word);
    op(0, 5'h06, 16'h0000, 16'h0004);
    op(0, 5'h07, 16'h0000, 16'h2001);
    op(0, 5'h08, 16'h0000, 16'h0000);
    op(0, 5'h1F, 16'h0000, 16'h0000);
    w = xs();
    op(1, 5'h07, w, 16'h0000);
    op(0, 5'h07, 16'h0000, w & 16'hB7FF);
    chk("tx_word", w & 16'hB7FF, tx_word);
    pulse(tx_done);
    op(0, 5'h07, 16'h0000, (w & 16'hB7FF) | 16'h0800);
    chk("tx_word", (w & 16'hB7FF) | 16'h0800, tx_word);
    op(1, 5'h06, 16'hFFFF, 16'h0000);
    op(1, 5'h08, 16'hFFFF, 16'h0000);
    op(0, 5'h08, 16'h0000, 16'h0000);
    pg = xs();
    p_np = 1'b1;
    p_an = 1'b1;
    pulse(par_f);
    pulse(send);
    op(0, 5'h06, 16'h0000, 16'h001F);
    op(0, 5'h06, 16'h0000, 16'h000D);
    p_np = 1'b0;
    op(0, 5'h06, 16'h0000, 16'h0005);
    @(negedge ref_clk);
    req = '{1'b0, 1'b1, 5'h06, 16'h0000};
    par_f = 1'b1;
    exp_q.push_back(16'h0005);
    @(negedge ref_clk);
    req = '0;
    par_f = 1'b0;
    op(0, 5'h06, 16'h0000, 16'h0015);
    op(0, 5'h08, 16'h0000, pg & 16'hBFFF);
    repeat (2) @(negedge ref_clk);
    chk("pending", 16'h0000, 16'(exp_q.size()));
    close_out();
  end
endmodule
